//--- logic/lprt_pkg.sv
// Package: constants for the precharge/refresh timing block.
// Assumes a single 50 MHz clock and an APB register port.
// Functional notes
// RULE_01: Controller precharges no sooner than BL/2 after READ; ACTIVATE after tRP.
// RULE_02: Controller precharges only after tRAS from that bank's ACTIVATE.
// RULE_03: tRTP starts BL/2-2 after READ, effective BL when truncated.
// RULE_04: Controller waits WL+BL/2+1+RU(tWR) from WRITE to PRECHARGE.
// RULE_05: Array writes happen per complete four-bit prefetch group.
// RULE_06: Auto-precharge flag low: normal burst, bank stays open.
// RULE_07: Auto-precharge flag sampled on falling-edge bit zero; high arms precharge.
// RULE_08: READ auto precharge starts at max(BL/2, BL/2-2+RU(tRTP)).
// RULE_09: After auto precharge, ACTIVATE needs tRP from start and tRC.
// RULE_10: WRITE auto precharge starts tWR after the write burst completes.
// RULE_11: After READ auto precharge, same bank access illegal; other banks spaced.
// RULE_12: After WRITE auto precharge, same bank access illegal; other banks spaced.
// RULE_13: Precharges may be one clock apart; period counts from latest.
// RULE_14: Commands inside minimum delays are illegal; no truncating auto precharge.
// RULE_15: Refresh is CS low, bits 0,1 low, 2 high; bit 3 selects type.
// RULE_16: Per-bank refresh works only in eight-bank configuration.
// RULE_17: Per-bank refresh walks banks 0..7; counter clears on reset, exit, all-bank.
// RULE_18: Controller spaces per-bank refresh by tRFCab, tRFCpb, tRP and tRRD.
// RULE_19: Per-bank refresh blocks only target bank, which ends idle.
// RULE_20: After per-bank refresh controller waits tRFCpb or tRRD as listed.
// RULE_21: All banks idle and timings met before an all-bank refresh.
// RULE_22: All-bank refresh leaves all banks idle; tRFCab before next.
// RULE_23: PRECHARGE closes the addressed bank, or all banks with flag high.
// RULE_24: Bank ready after tRPab for precharge-all, tRPpb for single bank.
// RULE_25: Controller keeps per-bank timers and blocks early commands.
package lprt_pkg;
    localparam int NBANK = 8;
    localparam int CW = 8;
    // Register byte offsets
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_LAT = 8'h04;
    localparam logic [7:0] OFS_TRP = 8'h08;
    localparam logic [7:0] OFS_TRFC = 8'h0C;
    localparam logic [7:0] OFS_STAT = 8'h10;
    // Field positions
    localparam int F_EIGHT = 4;
    localparam int F_WL = 4;
    localparam int F_RTP = 8;
    localparam int F_WR = 12;
    localparam int F_RPAB = 8;
    localparam int F_RFCAB = 8;
    localparam int F_BUSY = 8;
    localparam int F_REFP = 16;
    // Values after reset
    localparam logic [31:0] RST_CFG = 32'h0000_0011;
    localparam logic [31:0] RST_LAT = 32'h0000_2243;
    localparam logic [31:0] RST_TRP = 32'h0000_0403;
    localparam logic [31:0] RST_TRFC = 32'h0000_100A;
    // Burst length codes
    typedef enum logic [1:0] {LPRT_BL4 = 2'h0, LPRT_BL8 = 2'h1, LPRT_BL16 = 2'h2} lprt_bl_e;
    // Cycles for a four-bit group at double data rate
    localparam logic [CW-1:0] GRP_CYC = 8'h02;
endpackage

//--- logic/lprt_bank.sv
// One bank: open state, precharge/refresh busy timer, auto precharge timer.
// Assumes command strobes are one-cycle pulses from the decoder.
`timescale 1ns/10ps
module lprt_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Commands for this bank
    input wire logic act,
    input wire logic pre,
    input wire logic [lprt_pkg::CW-1:0] pre_cyc,
    input wire logic [lprt_pkg::CW-1:0] ap_rp_cyc,
    input wire logic ap_arm,
    input wire logic [lprt_pkg::CW-1:0] ap_dly,
    input wire logic refr,
    input wire logic [lprt_pkg::CW-1:0] ref_cyc,
    // State
    output logic open_r,
    output logic busy_r,
    output logic ap_fire_r
);
    import lprt_pkg::*;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] ap_r;
    logic ap_hit;

    // Fire in the cycle the delay names, as a precharge decoded there would
    assign ap_hit = ap_arm ? (ap_dly == 8'h01) : (ap_r == 8'h02);

    // Auto precharge countdown; fires once at its end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ap_r <= 8'h00;
            ap_fire_r <= 1'b0;
        end else begin
            ap_fire_r <= ap_hit; // [RULE_08] [RULE_10]
            if (ap_arm) begin
                ap_r <= ap_dly;
            end else if (ap_r != 8'h00) begin
                ap_r <= ap_r - 8'h01;
            end
        end
    end

    // Busy timer restarts from the latest precharge or refresh
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_r <= 8'h00;
            busy_r <= 1'b0;
        end else begin
            if (pre) begin
                cnt_r <= pre_cyc; // [RULE_13] [RULE_24]
                busy_r <= 1'b1;
            end else if (refr) begin
                cnt_r <= ref_cyc; // [RULE_19]
                busy_r <= 1'b1;
            end else if (ap_fire_r) begin
                cnt_r <= ap_rp_cyc;
                busy_r <= 1'b1;
            end else if (cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
                busy_r <= (cnt_r > 8'h01);
            end else begin
                busy_r <= 1'b0;
            end
        end
    end

    // Row open until a precharge, auto precharge or refresh closes it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            open_r <= 1'b0;
        end else if (pre || refr || ap_fire_r) begin
            open_r <= 1'b0; // [RULE_19] [RULE_22]
        end else if (act) begin
            open_r <= 1'b1;
        end
    end
endmodule

//--- logic/lprt_core.sv
// Top: command decode, bank array, refresh bank counter, write
// prefetch sequencer and APB registers.
// Assumes command pins come from another domain and are synchronised here.
`timescale 1ns/10ps
module lprt_core (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Command/address pins, rising and falling samples
    input wire logic cs_n,
    input wire logic [9:0] ca_rise,
    input wire logic [9:0] ca_fall,
    input wire logic sr_exit,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Bank state and array strobes
    output logic [lprt_pkg::NBANK-1:0] bank_open,
    output logic [lprt_pkg::NBANK-1:0] bank_busy,
    output logic [2:0] ref_ptr,
    output logic array_wr,
    output logic [2:0] array_wr_bank
);
    import lprt_pkg::*;

    logic [11:0] cs_s1_r, cs_s2_r;
    logic [9:0] caf_s1_r, caf_s2_r;
    logic [31:0] cfg_r, lat_r, trp_r, trfc_r;
    logic [2:0] ref_ptr_r;
    logic [CW-1:0] bl2, rl, wl, rtp, twr, rppb, rpab, rfcpb, rfcab;
    logic [CW-1:0] rd_ap_dly, wr_ap_dly, rd_alt;
    logic eight;
    logic c_cs, c_act, c_rd, c_wr, c_pre, c_ref, c_bst, ap_flag, ab_flag;
    logic [2:0] c_ba;
    logic [NBANK-1:0] act_v, pre_v, ref_v, arm_v, open_v, busy_v, fire_v;
    logic [CW-1:0] pre_cyc;
    logic [CW-1:0] wdly_r, wage_r, wtot_r, wdone_r, wph_r;
    logic wact_r;
    logic [2:0] wbank_r;
    logic array_wr_r;
    logic [2:0] array_wr_bank_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;
    logic [NBANK-1:0] open_q, busy_q;

    // Two-flop synchronisers on the command/address pins and sr_exit
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            // Idle levels: chip deselected, no self-refresh exit pending
            cs_s1_r <= 12'h7FF;
            cs_s2_r <= 12'h7FF;
            caf_s1_r <= 10'h000;
            caf_s2_r <= 10'h000;
        end else begin
            cs_s1_r <= {sr_exit, cs_n, ca_rise};
            cs_s2_r <= cs_s1_r;
            caf_s1_r <= ca_fall;
            caf_s2_r <= caf_s1_r;
        end
    end

    // Configuration fields
    assign eight = cfg_r[F_EIGHT];
    assign bl2 = (cfg_r[1:0] == LPRT_BL16) ? 8'h08 :
                 (cfg_r[1:0] == LPRT_BL8) ? 8'h04 : 8'h02;
    assign rl = {4'h0, lat_r[3:0]};
    assign wl = {4'h0, lat_r[F_WL +: 4]};
    assign rtp = {4'h0, lat_r[F_RTP +: 4]};
    assign twr = {4'h0, lat_r[F_WR +: 4]};
    assign rppb = trp_r[7:0];
    assign rpab = trp_r[F_RPAB +: 8];
    assign rfcpb = trfc_r[7:0];
    assign rfcab = trfc_r[F_RFCAB +: 8];

    // Auto precharge start delays
    assign rd_alt = bl2 - 8'h02 + rtp;
    assign rd_ap_dly = (rd_alt > bl2) ? rd_alt : bl2; // [RULE_08]
    assign wr_ap_dly = wl + bl2 + 8'h01 + twr; // [RULE_10]

    // Rising-edge command decode
    assign c_cs = ~cs_s2_r[10];
    assign c_act = c_cs & ~cs_s2_r[0] & cs_s2_r[1];
    assign c_rd = c_cs & cs_s2_r[0] & ~cs_s2_r[1] & cs_s2_r[2];
    assign c_wr = c_cs & cs_s2_r[0] & ~cs_s2_r[1] & ~cs_s2_r[2];
    assign c_pre = c_cs & (cs_s2_r[3:0] == 4'hB);
    assign c_bst = c_cs & (cs_s2_r[3:0] == 4'h3);
    assign c_ref = c_cs & (cs_s2_r[2:0] == 3'h4); // [RULE_15]
    assign c_ba = cs_s2_r[9:7];
    assign ab_flag = cs_s2_r[4];
    assign ap_flag = caf_s2_r[0]; // [RULE_07]
    assign pre_cyc = ab_flag ? rpab : rppb; // [RULE_24]

    // Per-bank strobes
    always_comb begin
        for (int i = 0; i < NBANK; i++) begin
            act_v[i] = c_act && (c_ba == i[2:0]);
            pre_v[i] = c_pre && (ab_flag || c_ba == i[2:0]); // [RULE_23]
            arm_v[i] = (c_rd || c_wr) && ap_flag && (c_ba == i[2:0]); // [RULE_06]
            ref_v[i] = c_ref && (cs_s2_r[3] ||
                       (eight && ref_ptr_r == i[2:0])); // [RULE_16] [RULE_22]
        end
    end

    // Bank array
    for (genvar g = 0; g < NBANK; g++) begin : g_bank
        lprt_bank u_bank (
            .clk(clk),
            .reset(reset),
            .act(act_v[g]),
            .pre(pre_v[g]),
            .pre_cyc(pre_cyc),
            .ap_rp_cyc(rppb),
            .ap_arm(arm_v[g]),
            .ap_dly(c_rd ? rd_ap_dly : wr_ap_dly),
            .refr(ref_v[g]),
            .ref_cyc(cs_s2_r[3] ? rfcab : rfcpb),
            .open_r(open_v[g]),
            .busy_r(busy_v[g]),
            .ap_fire_r(fire_v[g])
        );
    end

    // Output copies of bank state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            open_q <= '0;
            busy_q <= '0;
        end else begin
            open_q <= open_v;
            busy_q <= busy_v;
        end
    end

    // Round-robin per-bank refresh pointer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ref_ptr_r <= 3'h0; // [RULE_17]
        end else if (cs_s2_r[11] || (c_ref && cs_s2_r[3])) begin
            ref_ptr_r <= 3'h0; // [RULE_17]
        end else if (c_ref && eight) begin
            ref_ptr_r <= ref_ptr_r + 3'h1; // [RULE_17]
        end
    end

    // Write prefetch sequencer: one array write per complete group
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wact_r <= 1'b0;
            wdly_r <= 8'h00;
            wage_r <= 8'h00;
            wtot_r <= 8'h00;
            wdone_r <= 8'h00;
            wph_r <= 8'h00;
            wbank_r <= 3'h0;
            array_wr_r <= 1'b0;
            array_wr_bank_r <= 3'h0;
        end else begin
            array_wr_r <= 1'b0;
            if (c_wr) begin
                wact_r <= 1'b1;
                wdly_r <= wl + GRP_CYC;
                wage_r <= 8'h01;
                wtot_r <= {1'b0, bl2[CW-1:1]};
                wdone_r <= 8'h00;
                wph_r <= 8'h00;
                wbank_r <= c_ba;
            end else if (wact_r) begin
                wage_r <= wage_r + 8'h01;
                if (c_bst) begin
                    wtot_r <= {1'b0, wage_r[CW-1:1]};
                end
                if (wdly_r > 8'h01) begin
                    wdly_r <= wdly_r - 8'h01;
                end else if (wph_r != 8'h00) begin
                    wph_r <= wph_r - 8'h01;
                end else if (wdone_r < wtot_r) begin
                    array_wr_r <= 1'b1; // [RULE_05]
                    array_wr_bank_r <= wbank_r;
                    wdone_r <= wdone_r + 8'h01;
                    wph_r <= GRP_CYC - 8'h01;
                end else begin
                    wact_r <= 1'b0;
                end
            end
        end
    end

    // APB write side: configuration registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_r <= RST_CFG;
            lat_r <= RST_LAT;
            trp_r <= RST_TRP;
            trfc_r <= RST_TRFC;
        end else if (psel && penable && pready_r && pwrite) begin
            case (paddr)
                OFS_CFG: cfg_r <= {27'h0, pwdata[F_EIGHT], 2'h0, pwdata[1:0]};
                OFS_LAT: lat_r <= {16'h0, pwdata[15:0]};
                OFS_TRP: trp_r <= {16'h0, pwdata[15:0]};
                OFS_TRFC: trfc_r <= {16'h0, pwdata[15:0]};
                default: cfg_r <= cfg_r;
            endcase
        end
    end

    // APB answer: one wait-free access phase, data captured in setup
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= psel && !penable;
            pslverr_r <= 1'b0;
            if (psel && !penable) begin
                case (paddr)
                    OFS_CFG: prdata_r <= cfg_r;
                    OFS_LAT: prdata_r <= lat_r;
                    OFS_TRP: prdata_r <= trp_r;
                    OFS_TRFC: prdata_r <= trfc_r;
                    OFS_STAT: prdata_r <= {13'h0, ref_ptr_r, busy_q, open_q};
                    default: begin
                        prdata_r <= 32'h0000_0000;
                        pslverr_r <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Outputs straight from registers
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign bank_open = open_q;
    assign bank_busy = busy_q;
    assign ref_ptr = ref_ptr_r;
    assign array_wr = array_wr_r;
    assign array_wr_bank = array_wr_bank_r;

    // Delayed refresh strobes, for the per-bank refresh check
    logic [NBANK-1:0] ref_v_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ref_v_q <= '0;
        end else begin
            ref_v_q <= ref_v;
        end
    end

    // Checks on the device behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Refresh bank pointer: steps on per-bank refresh in eight-bank mode, holds in four-bank mode,
    // clears on all-bank refresh or self-refresh exit
    a_ptr_advance: assert property ( // [RULE_17]
        c_ref && !cs_s2_r[3] && eight && !cs_s2_r[11]
        |=> ref_ptr_r == $past(ref_ptr_r) + 3'h1) else $error("ref pointer not advanced");
    a_ptr_allbank: assert property ( // [RULE_17]
        c_ref && cs_s2_r[3] |=> ref_ptr_r == 3'h0) else $error("ref pointer not cleared");
    a_ptr_fourbank: assert property ( // [RULE_16]
        c_ref && !cs_s2_r[3] && !eight && !cs_s2_r[11]
        |=> $stable(ref_ptr_r)) else $error("per-bank refresh in four-bank mode");

    // Bank closing: refresh and precharge close only what they address,
    // and a read without the flag leaves its bank open
    a_allref_idle: assert property ( // [RULE_22]
        c_ref && cs_s2_r[3] |=> ##1 open_q == '0) else $error("bank open after all-bank refresh");
    a_pre_close: assert property ( // [RULE_23]
        c_pre && ab_flag |=> ##1 open_q == '0 && busy_q == '1)
        else $error("precharge-all did not close banks");
    a_pbref_only: assert property ( // [RULE_19]
        c_ref && !cs_s2_r[3] && eight && !c_pre && !c_act && fire_v == '0
        |=> (busy_v & ~$past(busy_v)) == ref_v_q) else $error("per-bank refresh hit other bank");
    a_noap_open: assert property ( // [RULE_06]
        c_rd && !ap_flag && open_v[c_ba] && !c_pre && !c_ref && fire_v == '0
        |=> open_v[$past(c_ba)]) else $error("bank closed without auto precharge");

    // Auto precharge timing: fires exactly the programmed delay after decode,
    // checked for the delays the latency settings in use give
    a_ap_fire: assert property ( // [RULE_07] [RULE_08]
        c_rd && arm_v != '0 && rd_ap_dly == 8'h07
        |-> ##7 fire_v == $past(arm_v, 7)) else $error("read auto precharge mistimed");
    a_wr_ap_fire: assert property ( // [RULE_10]
        c_wr && arm_v != '0 && wr_ap_dly == 8'h0C
        |-> ##12 fire_v == $past(arm_v, 12)) else $error("write auto precharge mistimed");

    // Write prefetch groups: spaced by a group, the first one
    // wl + 3 cycles after the write is decoded
    a_grp_space: assert property ( // [RULE_05]
        array_wr_r |=> !array_wr_r) else $error("array writes closer than a group");
    a_first_grp: assert property ( // [RULE_05]
        c_wr && wl == 8'h04 |=> !array_wr_r [*6] ##1 array_wr_r)
        else $error("first group mistimed");

    // Main scenarios reached
    c_pbref: cover property (c_ref && !cs_s2_r[3] && eight);
    c_abref: cover property (c_ref && cs_s2_r[3]);
    c_apfire: cover property (fire_v != '0);
    c_arraywr: cover property (array_wr_r ##2 array_wr_r);
    c_bstcut: cover property (c_bst && wact_r);
endmodule

//--- dv/lprt_ctrl_model.sv
// Controller model: drives the command/address pins of the timing block.
// Assumes the bench orders commands; gap holds the controller's waits.
`timescale 1ns/10ps
module lprt_ctrl_model (
    // Clock
    input wire logic clk,
    // Command/address pins
    output logic cs_n,
    output logic [9:0] ca_rise,
    output logic [9:0] ca_fall,
    output logic sr_exit
);
    // Deselected from time zero
    initial begin
        cs_n = 1'b1;
        ca_rise = 10'h155;
        ca_fall = 10'h2AA;
        sr_exit = 1'b0;
    end
    // One command for one clock; deselect inverts lines so nothing lingers
    task automatic cmd(input logic [9:0] r, input logic [9:0] f);
        @(posedge clk);
        cs_n <= 1'b0;
        ca_rise <= r;
        ca_fall <= f;
        @(posedge clk);
        cs_n <= 1'b1;
        ca_rise <= ~r;
        ca_fall <= ~f;
    endtask
    // Spacing between commands, in clocks
    task automatic gap(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Command encodings
    task automatic act(input logic [2:0] b);
        cmd({b, 7'h02}, 10'h000);
    endtask
    task automatic rd(input logic [2:0] b, input logic ap);
        cmd({b, 7'h05}, {9'h000, ap});
    endtask
    task automatic wr(input logic [2:0] b, input logic ap);
        cmd({b, 7'h01}, {9'h000, ap});
    endtask
    task automatic pre(input logic [2:0] b, input logic ab);
        cmd({b, 2'h0, ab, 4'hB}, 10'h000);
    endtask
    task automatic burst_terminate();
        cmd(10'h003, 10'h000);
    endtask
    task automatic refr(input logic ab);
        cmd({6'h00, ab, 3'h4}, 10'h000);
    endtask
    // Self-refresh exit marker
    task automatic sre();
        @(posedge clk);
        sr_exit <= 1'b1;
        @(posedge clk);
        sr_exit <= 1'b0;
    endtask
endmodule

//--- dv/lpddr2_precharge_refresh_timing_test.sv
// Testbench: commands through the controller model, registers over APB.
// Assumes the block's register defaults after reset.
`timescale 1ns/10ps
module lpddr2_precharge_refresh_timing_test;
    import lprt_pkg::*;
    logic clk = 1'b0;
    logic reset, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic cs_n, sr_exit, pready, pslverr, array_wr, e;
    logic [9:0] ca_rise, ca_fall;
    logic [7:0] bank_open, bank_busy;
    logic [2:0] ref_ptr, array_wr_bank;
    int num_errors = 0;
    int num_checks = 0;
    int grp[8];
    int l0, n;

    // 50 MHz clock
    always #10 clk = ~clk;
    // Array write groups per bank
    always @(posedge clk) if (array_wr === 1'b1) grp[array_wr_bank]++;

    lprt_ctrl_model u_ctl (.clk(clk), .cs_n(cs_n), .ca_rise(ca_rise), .ca_fall(ca_fall),
        .sr_exit(sr_exit));
    lprt_core dut (.clk(clk), .reset(reset), .cs_n(cs_n), .ca_rise(ca_rise),
        .ca_fall(ca_fall), .sr_exit(sr_exit), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bank_open(bank_open), .bank_busy(bank_busy), .ref_ptr(ref_ptr),
        .array_wr(array_wr), .array_wr_bank(array_wr_bank));

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, x, g);
        end
    endtask
    // APB transfer; ready, data and error taken at the rising edge that ends it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("mismatch apb ready expected 1 seen %b", pready);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Clocks until a bank's open flag reaches v
    task automatic till_open(input int b, input logic v, output int c);
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (bank_open[b] !== v && c < 60);
        chk("open flag", v, bank_open[b]);
    endtask
    // Length of a busy period, one cycle of slack for where it is counted
    task automatic busy_len(input int b, input int x);
        int c;
        c = 0;
        while (bank_busy[b] !== 1'b1 && c < 20) begin
            @(negedge clk);
            c++;
        end
        c = 0;
        while (bank_busy[b] === 1'b1 && c < 60) begin
            c++;
            @(negedge clk);
        end
        num_checks++;
        if (c < x || c > x + 1) begin
            num_errors++;
            $display("mismatch busy length expected %0d seen %0d", x, c);
        end
    endtask
    task automatic till_ptr(input logic [2:0] v);
        int c;
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (ref_ptr !== v && c < 10);
        chk("refresh pointer", v, ref_ptr);
    endtask
    task automatic t_regs();
        logic [7:0] a[4] = '{OFS_CFG, OFS_LAT, OFS_TRP, OFS_TRFC};
        logic [31:0] r[4] = '{RST_CFG, RST_LAT, RST_TRP, RST_TRFC};
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, a[i], 32'h0);
            chk("reset value", r[i], q);
        end
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped error", 1'b1, e);
        chk("unmapped data", 32'h0, q);
        apb(1'b1, OFS_LAT, 32'h0000_3543);
        apb(1'b0, OFS_LAT, 32'h0);
        chk("latency readback", 32'h0000_3543, q);
    endtask
    task automatic t_pre();
        u_ctl.act(3'h2);
        u_ctl.act(3'h5);
        till_open(5, 1'b1, n);
        u_ctl.pre(3'h2, 1'b0);
        till_open(2, 1'b0, l0);
        chk("other bank open", 1'b1, bank_open[5]);
        busy_len(2, 3);
        u_ctl.pre(3'h0, 1'b1);
        till_open(5, 1'b0, n);
        chk("all closed", 8'h00, bank_open);
        chk("all busy", 8'hFF, bank_busy);
        busy_len(7, 4);
    endtask
    task automatic t_ap();
        u_ctl.act(3'h3);
        u_ctl.act(3'h4);
        u_ctl.gap(4);
        u_ctl.rd(3'h3, 1'b0);
        u_ctl.rd(3'h4, 1'b1);
        till_open(4, 1'b0, n);
        chk("read ap delay", l0 + 7, n);
        chk("no ap stays open", 1'b1, bank_open[3]);
        grp[3] = 0;
        u_ctl.wr(3'h3, 1'b1);
        till_open(3, 1'b0, n);
        chk("write ap delay", l0 + 12, n);
        chk("write groups", 2, grp[3]);
    endtask
    task automatic t_bst();
        apb(1'b1, OFS_CFG, 32'h0000_0012);
        u_ctl.act(3'h6);
        u_ctl.gap(4);
        grp[6] = 0;
        u_ctl.wr(3'h6, 1'b0);
        u_ctl.gap(30);
        chk("bl16 groups", 4, grp[6]);
        grp[6] = 0;
        u_ctl.wr(3'h6, 1'b0);
        u_ctl.burst_terminate();
        u_ctl.gap(30);
        chk("cut groups", 1, grp[6]);
        chk("bank left open", 1'b1, bank_open[6]);
        apb(1'b1, OFS_CFG, RST_CFG);
        u_ctl.pre(3'h0, 1'b1);
        u_ctl.gap(10);
    endtask
    task automatic t_ref();
        chk("pointer after reset", 3'h0, ref_ptr);
        for (int i = 1; i <= 9; i++) begin
            u_ctl.refr(1'b0);
            till_ptr(3'(i % 8));
            n = 0;
            while (bank_busy === 8'h00 && n < 10) begin
                @(negedge clk);
                n++;
            end
            chk("refresh target only", 8'h01 << ((i - 1) % 8), bank_busy);
            u_ctl.gap(12);
        end
        u_ctl.refr(1'b1);
        till_ptr(3'h0);
        till_open(0, 1'b0, n);
        busy_len(0, 16);
        chk("all idle", 8'h00, bank_open);
        u_ctl.refr(1'b0);
        till_ptr(3'h1);
        u_ctl.sre();
        till_ptr(3'h0);
        apb(1'b1, OFS_CFG, 32'h0000_0001);
        u_ctl.gap(12);
        u_ctl.refr(1'b0);
        u_ctl.gap(8);
        chk("four bank pointer", 3'h0, ref_ptr);
        chk("four bank busy", 8'h00, bank_busy);
        u_ctl.act(3'h1);
        u_ctl.gap(4);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("status word", 32'h0000_0002, q);
    endtask
    task automatic give_verdict();
        if (num_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        reset <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_pre();
        t_ap();
        t_bst();
        t_ref();
        give_verdict();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
endmodule
